// [verilog/usb_device_core_regs.sv]
`timescale 1ns/1ps
`include "usb_regs_consts.svh"
// What this block does
// R1 - frame number low byte readable
// R2 - frame number bits 10:8 readable
// R3 - frame capture, token accept, engine drive and event flags only when enabled
// R4 - answer only own seven-bit address
// R5 - manual transmit overrides engine line drive
// R6 - force se0 drives both lines low
// R7 - line state bit picks k or j
// R8 - differential receiver readable at bit 0
// R9 - manual mode gives direct pin access
// R10 - drive bit selects open-drain or push-pull
// R11 - d plus drive bit controls d plus
// R12 - d minus drive bit controls d minus
// R13 - legacy pull-ups follow their bit
// R14 - attach pull-up follows its bit
// R15 - pin levels readable, reset to one
// R16 - setup received flag set by engine
// R17 - in received flag set by engine
// R18 - out received flag set by engine while enabled
// R19 - acked out sets acked flag
// R20 - mode field steers endpoint answers
// R21 - toggle written by software or engine
// R22 - data valid shows error-free transfer
// R23 - byte count written by either side
// R24 - flags sticky until software clears
module usb_device_core_regs
	import usb_regs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// serial engine side
	input wire logic sof_valid,
	input wire logic [10:0] sof_frame,
	input wire logic tok_valid,
	input wire logic [6:0] tok_addr,
	input wire logic ev_setup_acked,
	input wire logic ev_in_token,
	input wire logic ev_out_packet,
	input wire logic ev_out_acked,
	input wire logic rx_done,
	input wire logic rx_toggle,
	input wire logic rx_ok,
	input wire logic [3:0] rx_count,
	input wire logic mode_load,
	input wire logic [3:0] mode_new,
	input wire logic eng_dp,
	input wire logic eng_dm,
	input wire logic eng_oe,
	output logic tok_accept,
	output logic [3:0] ep0_mode,
	output logic ep0_tx_toggle,
	output logic [3:0] ep0_tx_count,
	// bus pins
	input wire logic dp_in,
	input wire logic dm_in,
	output logic dp_out,
	output logic dp_oe,
	output logic dm_out,
	output logic dm_oe,
	output logic legacy_pullup_on,
	output logic attach_pullup_on
);
	logic [10:0] frame_r;
	logic [7:0] ctrl_r;
	logic manual_transmit_enable;
	logic force_single_ended_zero;
	logic manual_line_state;
	logic [4:0] mdrv_r;
	logic manual_access_mode;
	logic drive_cmos;
	logic dplus_drive_bit;
	logic dminus_drive_bit;
	logic legacy_pullup_enable;
	logic attach_pullup_enable;
	logic [3:0] flags_r;
	logic [3:0] mode_r;
	logic toggle_r;
	logic valid_r;
	logic [3:0] count_r;
	logic [1:0] line_in;
	logic [1:0] line_sync_r [2];
	logic dplus_level;
	logic dminus_level;
	logic diff_rx;
	logic [3:0] flag_set;
	logic [3:0] flag_clr;
	logic [7:0] rdata_nxt;
	logic [7:0] frame_low_word;
	logic [7:0] frame_high_word;
	logic [7:0] mtx_word;
	logic [7:0] mdrv_word;
	logic [7:0] ep0_word;
	logic [7:0] cnt_word;
	logic dp_nxt;
	logic dm_nxt;
	logic dp_oe_nxt;
	logic dm_oe_nxt;
	line_owner_t owner;
	logic wr_ctrl;
	logic wr_mtx;
	logic wr_mdrv;
	logic wr_ep0;
	logic wr_cnt;

	// one decode for all writes, so no two registers claim one strobe
	always_comb begin
		wr_ctrl = 1'b0;
		wr_mtx = 1'b0;
		wr_mdrv = 1'b0;
		wr_ep0 = 1'b0;
		wr_cnt = 1'b0;
		if (reg_wr) begin
			unique case (reg_addr)
				`OFF_DEV_EN_ADDR: wr_ctrl = 1'b1;
				`OFF_MANUAL_TX: wr_mtx = 1'b1;
				`OFF_MANUAL_DRIVE: wr_mdrv = 1'b1;
				`OFF_EP0_STATUS: wr_ep0 = 1'b1;
				`OFF_EP0_COUNT: wr_cnt = 1'b1;
				default: begin
				end
			endcase
		end
	end

	assign manual_access_mode = mdrv_r[4];
	assign drive_cmos = mdrv_r[3];
	assign dplus_drive_bit = mdrv_r[2];
	assign dminus_drive_bit = mdrv_r[1];
	assign legacy_pullup_enable = mdrv_r[0];
	assign dplus_level = line_sync_r[1][1];
	assign dminus_level = line_sync_r[0][1];
	assign diff_rx = dplus_level && !dminus_level; // R8

	// pins pass two stages before any logic reads them; reset to one
	assign line_in = {dp_in, dm_in};
	genvar li;
	generate
		for (li = 0; li < 2; li++) begin : g_sync
			always_ff @(posedge clk) begin
				if (rst) begin
					line_sync_r[li] <= 2'b11; // R15
				end else begin
					line_sync_r[li] <= {line_sync_r[li][0], line_in[li]};
				end
			end
		end
	endgenerate

	// frame capture only counts while enabled
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_r <= `RST_FRAME;
		end else if (sof_valid && ctrl_r[`BIT_DEV_EN]) begin
			frame_r <= sof_frame; // R1 R2 R3
		end
	end

	// enable and address share one write, so they never disagree
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r <= `RST_BYTE;
		end else if (wr_ctrl) begin
			ctrl_r <= reg_wdata;
		end
	end

	// registered so the accept decision is a clean one-cycle pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			tok_accept <= 1'b0;
		end else begin
			tok_accept <= tok_valid && ctrl_r[`BIT_DEV_EN] // R3
				&& tok_addr == ctrl_r[6:0]; // R4
		end
	end

	// bits are kept even while another owner drives the lines
	always_ff @(posedge clk) begin
		if (rst) begin
			manual_transmit_enable <= 1'b0;
			force_single_ended_zero <= 1'b0;
			manual_line_state <= 1'b0;
		end else if (wr_mtx) begin
			manual_transmit_enable <= reg_wdata[`BIT_MAN_TX_EN];
			force_single_ended_zero <= reg_wdata[`BIT_FORCE_SE0];
			manual_line_state <= reg_wdata[`BIT_LINE_STATE];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			mdrv_r <= 5'h00;
			attach_pullup_enable <= 1'b0;
		end else if (wr_mdrv) begin
			mdrv_r <= {reg_wdata[`BIT_MAN_MODE], reg_wdata[`BIT_DRIVE_CMOS],
				reg_wdata[`BIT_DP_DRIVE], reg_wdata[`BIT_DM_DRIVE],
				reg_wdata[`BIT_LEGACY_PU]};
			attach_pullup_enable <= reg_wdata[`BIT_ATTACH_PU];
		end
	end

	// manual io wins over manual transmit, which wins over the engine
	always_comb begin
		if (manual_access_mode) begin
			owner = drv_manual_io; // R9
		end else if (manual_transmit_enable) begin
			owner = drv_manual_tx; // R5
		end else begin
			owner = drv_engine; // R5
		end
	end

	always_comb begin
		dp_nxt = eng_dp;
		dm_nxt = eng_dm;
		dp_oe_nxt = eng_oe;
		dm_oe_nxt = eng_oe;
		unique case (owner)
			drv_engine: begin
				dp_oe_nxt = eng_oe && ctrl_r[`BIT_DEV_EN]; // R3
				dm_oe_nxt = eng_oe && ctrl_r[`BIT_DEV_EN]; // R3
			end
			drv_manual_tx: begin
				dp_oe_nxt = 1'b1;
				dm_oe_nxt = 1'b1;
				if (force_single_ended_zero) begin
					dp_nxt = 1'b0; // R6
					dm_nxt = 1'b0; // R6
				end else begin
					// j is d plus high, k is d minus high
					dp_nxt = manual_line_state; // R7
					dm_nxt = !manual_line_state; // R7
				end
			end
			drv_manual_io: begin
				// open drain only pulls low; a one releases the line
				dp_nxt = dplus_drive_bit; // R11
				dm_nxt = dminus_drive_bit; // R12
				dp_oe_nxt = drive_cmos || !dplus_drive_bit; // R10 R11
				dm_oe_nxt = drive_cmos || !dminus_drive_bit; // R10 R12
			end
		endcase
	end

	// pins change one cycle after their cause, so the mux never glitches
	always_ff @(posedge clk) begin
		if (rst) begin
			dp_out <= 1'b0;
			dm_out <= 1'b0;
			dp_oe <= 1'b0;
			dm_oe <= 1'b0;
		end else begin
			dp_out <= dp_nxt;
			dm_out <= dm_nxt;
			dp_oe <= dp_oe_nxt;
			dm_oe <= dm_oe_nxt;
		end
	end

	// pull-ups follow their bits whoever owns the lines
	always_ff @(posedge clk) begin
		if (rst) begin
			legacy_pullup_on <= 1'b0;
			attach_pullup_on <= 1'b0;
		end else begin
			legacy_pullup_on <= legacy_pullup_enable; // R13
			attach_pullup_on <= attach_pullup_enable; // R14
		end
	end

	// events while disabled are dropped, not held for later
	assign flag_set = {ev_setup_acked, ev_in_token, ev_out_packet,
		ev_out_acked} & {4{ctrl_r[`BIT_DEV_EN]}};
	// writing zero to a flag clears it, writing one leaves it
	assign flag_clr = wr_ep0 ? ~reg_wdata[7:4] : 4'h0;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_flag
			always_ff @(posedge clk) begin
				if (rst) begin
					flags_r[gi] <= 1'b0;
				end else if (flag_set[gi]) begin
					flags_r[gi] <= 1'b1; // R16 R17 R18 R19 R24
				end else if (flag_clr[gi]) begin
					flags_r[gi] <= 1'b0; // R24
				end
			end
		end
	endgenerate

	// engine mode update beats a software write in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_r <= 4'h0;
		end else if (mode_load) begin
			mode_r <= mode_new; // R20
		end else if (wr_ep0) begin
			mode_r <= reg_wdata[3:0]; // R20
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			toggle_r <= 1'b0;
			count_r <= 4'h0;
		end else if (rx_done) begin
			toggle_r <= rx_toggle; // R21
			count_r <= rx_count; // R23
		end else if (wr_cnt) begin
			toggle_r <= reg_wdata[`BIT_TOGGLE]; // R21
			count_r <= reg_wdata[3:0]; // R23
		end
	end

	// software only ever clears data valid, never sets it; the engine sets or clears it on rx_done
	always_ff @(posedge clk) begin
		if (rst) begin
			valid_r <= 1'b0;
		end else if (rx_done) begin
			valid_r <= rx_ok; // R22
		end else if (wr_cnt && !reg_wdata[`BIT_DATA_VALID]) begin
			valid_r <= 1'b0; // R22
		end
	end

	assign ep0_mode = mode_r;
	assign ep0_tx_toggle = toggle_r;
	assign ep0_tx_count = count_r;

	// readback words, built once so the read mux stays a plain select
	assign frame_low_word = frame_r[7:0]; // R1
	assign frame_high_word = {5'h00, frame_r[10:8]}; // R2
	assign mtx_word = {manual_transmit_enable, force_single_ended_zero,
		manual_line_state, 4'h0, diff_rx}; // R8
	assign mdrv_word = {mdrv_r, attach_pullup_enable, dplus_level,
		dminus_level}; // R15
	assign ep0_word = {flags_r, mode_r};
	assign cnt_word = {toggle_r, valid_r, 2'b00, count_r}; // R22

	always_comb begin
		rdata_nxt = 8'h00;
		unique case (reg_addr)
			`OFF_FRAME_LOW: rdata_nxt = frame_low_word; // R1
			`OFF_FRAME_HIGH: rdata_nxt = frame_high_word; // R2
			`OFF_DEV_EN_ADDR: rdata_nxt = ctrl_r;
			`OFF_MANUAL_TX: rdata_nxt = mtx_word; // R8
			`OFF_MANUAL_DRIVE: rdata_nxt = mdrv_word; // R15
			`OFF_EP0_STATUS: rdata_nxt = ep0_word;
			`OFF_EP0_COUNT: rdata_nxt = cnt_word; // R22
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= `RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= `RST_BYTE;
		end
	end
endmodule

// [common/usb_regs_consts.svh]
`ifndef USB_REGS_CONSTS_SVH
`define USB_REGS_CONSTS_SVH
`define OFF_FRAME_LOW 8'h31
`define OFF_FRAME_HIGH 8'h32
`define OFF_DEV_EN_ADDR 8'h33
`define OFF_MANUAL_TX 8'h34
`define OFF_MANUAL_DRIVE 8'h35
`define OFF_EP0_STATUS 8'h36
`define OFF_EP0_COUNT 8'h37
`define RST_BYTE 8'h00
`define RST_FRAME 11'h000
`define BIT_DEV_EN 7
`define BIT_MAN_TX_EN 7
`define BIT_FORCE_SE0 6
`define BIT_LINE_STATE 5
`define BIT_MAN_MODE 7
`define BIT_DRIVE_CMOS 6
`define BIT_DP_DRIVE 5
`define BIT_DM_DRIVE 4
`define BIT_LEGACY_PU 3
`define BIT_ATTACH_PU 2
`define BIT_SETUP_RX 7
`define BIT_IN_RX 6
`define BIT_OUT_RX 5
`define BIT_ACKED 4
`define BIT_TOGGLE 7
`define BIT_DATA_VALID 6
`endif

// [common/usb_regs_pkg.sv]
package usb_regs_pkg;
	typedef enum logic [1:0] {
		drv_engine,
		drv_manual_tx,
		drv_manual_io
	} line_owner_t;
endpackage

// [dv/usb_regs_monitor.sv]
`timescale 1ns/1ps
module usb_regs_monitor (
	// clock, reset and register port
	input logic clk,
	input logic rst,
	input logic [7:0] reg_addr,
	input logic [7:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [7:0] reg_rdata,
	// engine side
	input logic sof_valid,
	input logic [10:0] sof_frame,
	input logic tok_valid,
	input logic [6:0] tok_addr,
	input logic tok_accept,
	// pins
	input logic dp_out,
	input logic dp_oe,
	input logic dm_out,
	input logic dm_oe,
	input logic legacy_pullup_on,
	input logic attach_pullup_on
);
	logic en_r;
	logic man_r;
	logic [6:0] ad_r;
	logic [10:0] fr_r;
	logic [1:0] pu_r;
	wire w33 = reg_wr && reg_addr == 8'h33;
	wire w34 = reg_wr && reg_addr == 8'h34;
	wire w35 = reg_wr && reg_addr == 8'h35;
	// shadow copies, since the checker cannot see the register bodies
	always_ff @(posedge clk) begin
		if (rst) begin
			{en_r, ad_r, man_r, fr_r, pu_r} <= '0;
		end else begin
			if (w33) {en_r, ad_r} <= reg_wdata;
			if (w35) {man_r, pu_r} <= {reg_wdata[7], reg_wdata[3:2]};
			if (sof_valid && en_r) fr_r <= sof_frame;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_frame;
		reg_rd && reg_addr == 8'h31 |=> reg_rdata == fr_r[7:0];
	endproperty
	a_frame: assert property (p_frame) else $error("frame");
	property p_tok_off;
		tok_valid && !en_r |=> !tok_accept;
	endproperty
	a_tok_off: assert property (p_tok_off) else $error("tok off");
	property p_tok_hit;
		tok_valid && en_r && tok_addr == ad_r |=> tok_accept;
	endproperty
	a_tok_hit: assert property (p_tok_hit) else $error("tok hit");
	property p_se0;
		w34 && reg_wdata[7:6] == 2'b11 && !man_r
			|-> ##[1:2] (dp_oe && dm_oe && !dp_out && !dm_out);
	endproperty
	a_se0: assert property (p_se0) else $error("se0");
	property p_j;
		w34 && reg_wdata[7:5] == 3'b101 && !man_r
			|-> ##[1:2] (dp_oe && dp_out && !dm_out);
	endproperty
	a_j: assert property (p_j) else $error("j");
	property p_dm;
		w35 && reg_wdata[7] && !reg_wdata[4] |-> ##[1:2] (dm_oe && !dm_out);
	endproperty
	a_dm: assert property (p_dm) else $error("dm");
	property p_legacy;
		w35 |-> ##[1:2] legacy_pullup_on == pu_r[1];
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy");
	property p_attach;
		w35 |-> ##[1:2] attach_pullup_on == pu_r[0];
	endproperty
	a_attach: assert property (p_attach) else $error("attach");
endmodule
bind usb_device_core_regs usb_regs_monitor usb_regs_monitor_i (.*);

// [dv/usb_host_model.sv]
`timescale 1ns/1ps
module usb_host_model (
	// device drive and pull-ups
	input logic dp_out,
	input logic dp_oe,
	input logic dm_out,
	input logic dm_oe,
	input logic legacy_pullup_on,
	input logic attach_pullup_on,
	// host drive, high on both lines while set
	input logic host_oe,
	// resolved lines
	output logic dp_in,
	output logic dm_in
);
	// host pull-downs: a released line with no pull-up and no host drive falls to 0
	assign dp_in = dp_oe ? dp_out
		: (host_oe | legacy_pullup_on | attach_pullup_on);
	assign dm_in = dm_oe ? dm_out : (host_oe | legacy_pullup_on);
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	typedef struct {logic h, w; logic [7:0] a, d, e;} row_t;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, host_oe = 1;
	logic sof_valid = 0, tok_valid = 0, rx_done = 0, rx_toggle = 0;
	logic rx_ok = 0, mode_load = 0, eng_dp = 0, eng_dm = 0, eng_oe = 0;
	logic ev_setup_acked = 0, ev_in_token = 0;
	logic ev_out_packet = 0, ev_out_acked = 0;
	logic [3:0] rx_count = 0, mode_new = 0, ep0_mode, ep0_tx_count;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [10:0] sof_frame = 0;
	logic [6:0] tok_addr = 0;
	logic tok_accept, ep0_tx_toggle, dp_in, dm_in, dp_out, dp_oe;
	logic dm_out, dm_oe, legacy_pullup_on, attach_pullup_on;
	int errors = 0, tests_run = 0;
	// host, write, offset, data, expected read
	row_t rows[19] = '{'{1,0,8'h31,8'h0,8'h0}, '{1,0,8'h32,8'h0,8'h0},
		'{1,0,8'h34,8'h0,8'h0}, '{1,0,8'h35,8'h0,8'h3},
		'{1,1,8'h31,8'hAA,8'h0}, '{1,1,8'h33,8'h85,8'h85},
		'{0,1,8'h36,8'hF,8'hF}, '{0,1,8'h37,8'hFF,8'h8F},
		'{0,0,8'h3F,8'h0,8'h0}, '{0,1,8'h35,8'hC,8'hF},
		'{0,1,8'h35,8'h4,8'h6}, '{0,1,8'h34,8'hA0,8'hA1},
		'{0,1,8'h34,8'h80,8'h80}, '{0,1,8'h34,8'hC0,8'hC0},
		'{0,1,8'h34,8'h0,8'h1}, '{0,1,8'h35,8'hA0,8'hA0},
		'{0,1,8'h35,8'hA8,8'hAA}, '{0,1,8'h35,8'hF0,8'hF3},
		'{0,1,8'h35,8'h0,8'h0}};
	always #12.5 clk = ~clk;
	usb_host_model usb_host_model_i (.*);
	usb_device_core_regs usb_device_core_regs_i (.*);
	task automatic chk(input logic [7:0] g, x);
		tests_run++;
		if (g !== x) begin
			errors++;
			$display("wrong value t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge clk);
		reg_wr <= 0;
	endtask
	// read data stand one cycle only, so sample just after that edge
	task automatic rd(input logic [7:0] a, x);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge clk);
		reg_rd <= 0;
		#1;
		chk(reg_rdata, x);
	endtask
	task automatic tk(input logic [6:0] a, input logic x);
		@(posedge clk);
		tok_addr <= a;
		tok_valid <= 1;
		@(posedge clk);
		tok_valid <= 0;
		#1;
		chk({7'h0, tok_accept}, {7'h0, x});
	endtask
	task automatic ev(input logic [3:0] f);
		@(posedge clk);
		{ev_setup_acked, ev_in_token, ev_out_packet, ev_out_acked} <= f;
		@(posedge clk);
		{ev_setup_acked, ev_in_token, ev_out_packet, ev_out_acked} <= 4'h0;
	endtask
	task automatic summarize;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		foreach (rows[i]) begin
			host_oe <= rows[i].h;
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			repeat (4) @(posedge clk);
			rd(rows[i].a, rows[i].e);
		end
		@(posedge clk);
		sof_frame <= 11'h5A3;
		sof_valid <= 1;
		@(posedge clk);
		sof_valid <= 0;
		rd(8'h31, 8'hA3);
		rd(8'h32, 8'h05);
		tk(7'h05, 1);
		tk(7'h06, 0);
		ev(4'hF);
		{mode_load, mode_new, rx_done, rx_toggle, rx_ok,
			rx_count} <= 12'h9F9;
		@(posedge clk);
		{mode_load, rx_done} <= 2'b00;
		rd(8'h36, 8'hF3);
		rd(8'h37, 8'hC9);
		chk({ep0_mode, ep0_tx_count}, 8'h39);
		chk({7'h00, ep0_tx_toggle}, 8'h01);
		wr(8'h36, 8'h03);
		rd(8'h36, 8'h03);
		ev(4'h4);
		rd(8'h36, 8'h43);
		wr(8'h33, 8'h05);
		tk(7'h05, 0);
		ev(4'h8);
		rd(8'h36, 8'h43);
		eng_oe <= 1;
		eng_dp <= 1;
		repeat (4) @(posedge clk);
		rd(8'h34, 8'h00);
		wr(8'h33, 8'h85);
		repeat (4) @(posedge clk);
		rd(8'h34, 8'h01);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		rd(8'h35, 8'h03);
		rd(8'h33, 8'h00);
		summarize();
	end
	initial begin
		#50us;
		errors++;
		summarize();
	end
endmodule
